// ---- verilog/usr_pkg.sv ----
// usr_pkg: register map, field positions, reset values and shared types of the
// synchronous serial port. Assumes word-aligned AHB-Lite access, index * 4.
`default_nettype none
package usr_pkg;
  // ****************************************
  // register indices (byte address = index * 4)
  // ****************************************
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_FLAGS = 6'h10;
  localparam logic [5:0] IDX_IEN = 6'h11;
  localparam logic [5:0] IDX_RECEIVE_STATUS_CONTROL = 6'h13;
  localparam logic [5:0] IDX_RCBUF = 6'h14;
  localparam logic [5:0] IDX_TRANSMIT_STATUS_CONTROL = 6'h15;
  localparam logic [5:0] IDX_TXBUF = 6'h16;
  localparam logic [5:0] IDX_BAUD = 6'h17;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_RCFLAG = 0;
  localparam int B_TXFLAG = 1;
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_RX9 = 6;
  localparam int B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int B_FRAMING_ERROR = 2;
  localparam int B_OVERRUN_ERROR = 1;
  localparam int B_RECEIVED_NINTH_BIT = 0;
  localparam int B_CLOCK_SOURCE_SELECT = 7;
  localparam int B_TX9 = 6;
  localparam int B_TRANSMIT_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_TRMT = 1;
  localparam int B_TRANSMIT_NINTH_BIT = 0;
  // ****************************************
  // reset values and sizes
  // ****************************************
  localparam logic [7:0] FLAGS_RST = 8'h02;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_RST = 8'h00;
  localparam logic [7:0] TRANSMIT_STATUS_CONTROL_RST = 8'h02;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam int BAUD_W = 8;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam int RX_DEPTH = 2;

  typedef struct packed {
    logic framing_error;
    logic ninth;
    logic [7:0] data;
  } usr_entry_t;
endpackage
`default_nettype wire

// ---- verilog/usr_core_if.sv ----
// usr_core_if: links the port core to its receive queue and baud generator.
// Assumes all three sit on the same clock.
`default_nettype none
interface usr_core_if;
  logic push;
  usr_pkg::usr_entry_t push_ent;
  logic pop;
  logic full;
  logic empty;
  usr_pkg::usr_entry_t head;
  logic run;
  logic [usr_pkg::BAUD_W-1:0] divisor;
  logic tick;
  modport core (output push, push_ent, pop, run, divisor, input full, empty, head, tick);
  modport fifo (input push, push_ent, pop, output full, empty, head);
  modport brg (input run, divisor, output tick);
endinterface
`default_nettype wire

// ---- verilog/usr_rx_fifo.sv ----
// usr_rx_fifo: receive queue of data, ninth bit and error per entry.
// Assumes push is only offered when not full; pop of an empty queue is ignored.
`default_nettype none
module usr_rx_fifo #(
  parameter int DEPTH = usr_pkg::RX_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // core side
  usr_core_if.fifo fif
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);

  if (DEPTH < 2) begin : g_chk
    $error("usr_rx_fifo needs DEPTH of at least 2");
  end

  typedef struct packed {
    usr_pkg::usr_entry_t [DEPTH-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [CW-1:0] cnt;
  } usr_fifo_st_t;

  usr_fifo_st_t r, n;

  always_comb
  begin
    n = r;
    if (fif.pop && r.cnt != '0)
    begin
      n.rd = (r.rd == LAST) ? '0 : r.rd + 1'b1;
      n.cnt = n.cnt - 1'b1;
    end
    if (fif.push && r.cnt != FULLC)
    begin
      n.mem[r.wr] = fif.push_ent;
      n.wr = (r.wr == LAST) ? '0 : r.wr + 1'b1;
      n.cnt = n.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      r <= '0;
    else
      r <= n;
  end

  assign fif.full = (r.cnt == FULLC);
  assign fif.empty = (r.cnt == '0);
  assign fif.head = r.mem[r.rd];
endmodule
`default_nettype wire

// ---- verilog/usr_baud_gen.sv ----
// usr_baud_gen: pulses tick once every divisor + 1 clocks while run is high.
// Assumes run low holds the counter at zero.
`default_nettype none
module usr_baud_gen (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // core side
  usr_core_if.brg bif
);
  typedef struct packed {
    logic [usr_pkg::BAUD_W-1:0] cnt;
    logic tick;
  } usr_brg_st_t;

  usr_brg_st_t r, n;

  always_comb
  begin
    n = r;
    n.tick = 1'b0;
    if (!bif.run)
      n.cnt = '0;
    else if (r.cnt == bif.divisor)
    begin
      n.cnt = '0;
      n.tick = 1'b1;
    end
    else
      n.cnt = r.cnt + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      r <= '0;
    else
      r <= n;
  end

  assign bif.tick = r.tick;
endmodule
`default_nettype wire

// ---- verilog/usr_sync_port.sv ----
// usr_sync_port: half-duplex synchronous serial port, master or slave clock,
// with AHB-Lite register access. Assumes pins come from outside the clock domain.
//
// Functional notes
// - receive starts on single or continuous enable
// - data sampled on shift clock falling edge
// - single enable receives one word, then stops
// - continuous enable receives until cleared
// - both enables set acts as continuous
// - finished word moves to queue, sets flag
// - receive flag follows queue, not gated by any enable
// - receive queue holds two words
// - third word with full queue sets overrun
// - software clears overrun by clearing continuous enable
// - overrun blocks every move into queue
// - ninth bit queued with each word
// - data read advances ninth bit and error
// - dropping enables resets receive logic
// - clock select clear makes clock an input
// - slave transfers continue during sleep
// - transmit flag set when buffer moves out
// - enabled flag during sleep raises wake
// - slave ignores single receive enable
// - slave completes words during sleep
// - dropping transmit enables resets transmitter
// - transmit and receive never overlap
// - master drives clock pin when enabled
`default_nettype none
module usr_sync_port #(
  parameter int RX_DEPTH = usr_pkg::RX_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // serial pins
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  // core power state
  input wire logic sleep_i,
  output logic irq_o,
  output logic wake_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic dt_s1;
    logic dt_s2;
    logic serial_port_enable;
    logic ninth_bit_receive_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic overrun_error;
    logic clock_source_select;
    logic ninth_bit_transmit_enable;
    logic transmit_enable;
    logic sync_mode;
    logic transmit_ninth_bit;
    logic receive_irq_enable;
    logic transmit_irq_enable;
    logic [usr_pkg::BAUD_W-1:0] baud_divisor;
    logic [7:0] transmit_buffer;
    logic txbuf_full;
    logic [8:0] transmit_shift_register;
    logic [3:0] tx_cnt;
    logic tx_busy;
    logic [8:0] receive_shift_register;
    logic [3:0] rx_cnt;
    logic ninth_hold;
    logic ck_out;
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
    logic irq;
    logic wake;
    logic hready;
    logic [31:0] hrdata;
    logic ap_valid;
    logic ap_write;
    logic [usr_pkg::IDX_W-1:0] ap_idx;
  } usr_port_st_t;

  usr_port_st_t r, n;
  usr_core_if cif ();

  usr_rx_fifo #(
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .fif(cif.fifo)
  );

  usr_baud_gen u_baud_gen (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .bif(cif.brg)
  );

  logic sync_on, master, rx_on, tx_on, run, rise, fall, word_done;
  logic receive_flag, transmit_flag;
  logic [3:0] rx_bits, tx_bits;
  logic [8:0] rsr_nxt;
  logic [7:0] rd_val;

  // ****************************************
  // mode decode
  // ****************************************
  always_comb
  begin
    sync_on = r.serial_port_enable & r.sync_mode;
    master = r.clock_source_select;
    // slave looks only at the continuous enable; it also wins over single
    rx_on = sync_on & (r.continuous_receive_enable | (master & r.single_receive_enable));
    // receive overrides transmit so the data pin is never shared
    tx_on = sync_on & r.transmit_enable & ~rx_on;
    // generator sits in reset unless a transfer needs the clock; frozen in sleep
    run = sync_on & master & ~sleep_i & (rx_on | (tx_on & r.tx_busy));
    if (master)
    begin
      rise = run & cif.tick & ~r.ck_out;
      fall = run & cif.tick & r.ck_out;
    end
    else
    begin
      // slave edges come from the pin, so sleep of the core does not matter
      rise = r.ck_s2 & ~r.ck_s3;
      fall = ~r.ck_s2 & r.ck_s3;
    end
    rx_bits = r.ninth_bit_receive_enable ? usr_pkg::BITS_9 : usr_pkg::BITS_8;
    tx_bits = r.ninth_bit_transmit_enable ? usr_pkg::BITS_9 : usr_pkg::BITS_8;
    rsr_nxt = {r.dt_s2, r.receive_shift_register[8:1]};
    word_done = rx_on & fall & (r.rx_cnt + 4'h1 == rx_bits);
    receive_flag = ~cif.empty;
    transmit_flag = ~r.txbuf_full;
  end

  // ****************************************
  // register read mux
  // ****************************************
  always_comb
  begin
    rd_val = 8'h00;
    unique case (r.ap_idx)
      usr_pkg::IDX_FLAGS:
        rd_val = {6'h00, transmit_flag, receive_flag};
      usr_pkg::IDX_IEN:
        rd_val = {6'h00, r.transmit_irq_enable, r.receive_irq_enable};
      usr_pkg::IDX_RECEIVE_STATUS_CONTROL:
        rd_val = {r.serial_port_enable, r.ninth_bit_receive_enable, r.single_receive_enable,
                  r.continuous_receive_enable, 1'b0, cif.head.framing_error, r.overrun_error, cif.head.ninth};
      usr_pkg::IDX_RCBUF:
        rd_val = cif.head.data;
      usr_pkg::IDX_TRANSMIT_STATUS_CONTROL:
        rd_val = {r.clock_source_select, r.ninth_bit_transmit_enable, r.transmit_enable,
                  r.sync_mode, 2'b00, ~r.tx_busy, r.transmit_ninth_bit};
      usr_pkg::IDX_TXBUF:
        rd_val = r.transmit_buffer;
      usr_pkg::IDX_BAUD:
        rd_val = r.baud_divisor;
      default:
        rd_val = 8'h00;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    n = r;
    cif.push = 1'b0;
    cif.push_ent = '0;
    cif.pop = 1'b0;
    n.ck_s1 = serial_clock_pin_i;
    n.ck_s2 = r.ck_s1;
    n.ck_s3 = r.ck_s2;
    n.dt_s1 = serial_data_pin_i;
    n.dt_s2 = r.dt_s1;

    // master shift clock
    if (!run)
      n.ck_out = 1'b0;
    else if (cif.tick)
      n.ck_out = ~r.ck_out;
    n.ck_oe = sync_on & master;

    // transmitter; the holding buffer survives a reset so it may be loaded first
    if (!(sync_on & r.transmit_enable))
    begin
      n.tx_busy = 1'b0;
      n.tx_cnt = 4'h0;
    end
    else if (!r.tx_busy)
    begin
      if (r.txbuf_full && !rx_on)
      begin
        // buffer empties here, which is what raises the transmit flag
        n.transmit_shift_register = {r.transmit_ninth_bit, r.transmit_buffer};
        n.txbuf_full = 1'b0;
        n.tx_busy = 1'b1;
        n.tx_cnt = 4'h0;
      end
    end
    else if (rise && tx_on && r.tx_cnt != tx_bits)
    begin
      n.dt_out = r.transmit_shift_register[0];
      n.transmit_shift_register = {1'b0, r.transmit_shift_register[8:1]};
      n.tx_cnt = r.tx_cnt + 4'h1;
    end
    else if (fall && r.tx_cnt == tx_bits)
      n.tx_busy = 1'b0;
    n.dt_oe = tx_on;

    // bus: address phase, then data phase; reads take one wait state
    n.ap_valid = 1'b0;
    n.hready = 1'b1;
    if (r.ap_valid && !r.ap_write)
    begin
      n.hrdata = {24'h000000, rd_val};
      if (r.ap_idx == usr_pkg::IDX_RCBUF)
        cif.pop = 1'b1;
    end
    if (r.ap_valid && r.ap_write)
    begin
      unique case (r.ap_idx)
        usr_pkg::IDX_IEN:
        begin
          n.receive_irq_enable = hwdata_i[usr_pkg::B_RCFLAG];
          n.transmit_irq_enable = hwdata_i[usr_pkg::B_TXFLAG];
        end
        usr_pkg::IDX_RECEIVE_STATUS_CONTROL:
        begin
          n.serial_port_enable = hwdata_i[usr_pkg::B_SERIAL_PORT_ENABLE];
          n.ninth_bit_receive_enable = hwdata_i[usr_pkg::B_RX9];
          n.single_receive_enable = hwdata_i[usr_pkg::B_SINGLE_RECEIVE_ENABLE];
          n.continuous_receive_enable = hwdata_i[usr_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
          // overrun only goes away when software drops the continuous enable or the port enable
          if (!hwdata_i[usr_pkg::B_CONTINUOUS_RECEIVE_ENABLE] || !hwdata_i[usr_pkg::B_SERIAL_PORT_ENABLE])
            n.overrun_error = 1'b0;
        end
        usr_pkg::IDX_TRANSMIT_STATUS_CONTROL:
        begin
          n.clock_source_select = hwdata_i[usr_pkg::B_CLOCK_SOURCE_SELECT];
          n.ninth_bit_transmit_enable = hwdata_i[usr_pkg::B_TX9];
          n.transmit_enable = hwdata_i[usr_pkg::B_TRANSMIT_ENABLE];
          n.sync_mode = hwdata_i[usr_pkg::B_SYNC];
          n.transmit_ninth_bit = hwdata_i[usr_pkg::B_TRANSMIT_NINTH_BIT];
        end
        usr_pkg::IDX_TXBUF:
        begin
          n.transmit_buffer = hwdata_i[7:0];
          n.txbuf_full = 1'b1;
        end
        usr_pkg::IDX_BAUD:
          n.baud_divisor = hwdata_i[7:0];
        default:
        begin
        end
      endcase
    end
    if (hsel_i && hready_i && htrans_i[1])
    begin
      n.ap_valid = 1'b1;
      n.ap_write = hwrite_i;
      n.ap_idx = haddr_i[7:2];
      n.hready = hwrite_i;
    end

    // receiver; applied after bus writes so a hardware set beats a clear
    if (!rx_on)
      n.rx_cnt = 4'h0;
    else if (fall)
    begin
      n.receive_shift_register = rsr_nxt;
      n.rx_cnt = r.rx_cnt + 4'h1;
      if (word_done)
      begin
        n.rx_cnt = 4'h0;
        if (r.ninth_bit_receive_enable)
        begin
          cif.push_ent.data = rsr_nxt[7:0];
          cif.push_ent.ninth = rsr_nxt[8];
        end
        else
        begin
          cif.push_ent.data = rsr_nxt[8:1];
          cif.push_ent.ninth = r.ninth_hold;
        end
        if (r.overrun_error)
          cif.push = 1'b0;
        else if (cif.full)
          n.overrun_error = 1'b1;
        else
        begin
          cif.push = 1'b1;
          n.ninth_hold = cif.push_ent.ninth;
        end
        // single mode ends after one word unless continuous is also set
        if (!r.continuous_receive_enable)
          n.single_receive_enable = 1'b0;
      end
    end

    n.irq = (receive_flag & r.receive_irq_enable) | (transmit_flag & r.transmit_irq_enable);
    n.wake = sleep_i & n.irq;
  end

  assign cif.run = run;
  assign cif.divisor = r.baud_divisor;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r <= '0;
      r.txbuf_full <= ~usr_pkg::FLAGS_RST[usr_pkg::B_TXFLAG];
      r.hready <= 1'b1;
    end
    else
      r <= n;
  end

  assign hrdata_o = r.hrdata;
  assign hreadyout_o = r.hready;
  assign hresp_o = 1'b0;
  assign serial_clock_pin_o = r.ck_out;
  assign serial_clock_pin_oe_o = r.ck_oe;
  assign serial_data_pin_o = r.dt_out;
  assign serial_data_pin_oe_o = r.dt_oe;
  assign irq_o = r.irq;
  assign wake_o = r.wake;
endmodule
`default_nettype wire

// ---- tb/usr_sync_port_chk.sv ----
// usr_sync_port_chk: bus timing and pin assertions on the serial port's top.
// Assumes one clock domain and hready_i wired to hreadyout_o.
`default_nettype none
module usr_sync_port_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // ahb-lite
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // pins and power
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic sleep_i,
  input wire logic irq_o,
  input wire logic wake_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_take;
    hsel_i && hready_i && htrans_i[1];
  endsequence
  sequence s_rd_answer;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  chk_read_wait: assert property ((s_take ##0 !hwrite_i) |=> s_rd_answer)
    else $error("read wait state wrong");
  chk_write_ready: assert property ((s_take ##0 hwrite_i) |=> hreadyout_o)
    else $error("write stalled");
  chk_resp_okay: assert property (hresp_o == 1'h0)
    else $error("response not okay");
  // read data may only move at the edge that ends a read's wait cycle
  chk_rdata_hold: assert property ($changed(hrdata_o) |-> !$past(hreadyout_o))
    else $error("read data moved outside a read");
  chk_wake_sleep: assert property (wake_o |-> $past(sleep_i))
    else $error("wake without sleep");
  chk_wake_irq: assert property (wake_o |-> irq_o)
    else $error("wake without interrupt");
  chk_clk_idle: assert property (!serial_clock_pin_oe_o [*2] |-> !serial_clock_pin_o)
    else $error("clock pin not idle low");
  // the edge on which sleep is first seen may still launch one toggle
  chk_clk_frozen: assert property (sleep_i [*3] |-> $stable(serial_clock_pin_o))
    else $error("master clock moved in sleep");
endmodule
bind usr_sync_port usr_sync_port_chk usr_sync_port_chk_inst (.clk_i, .reset_i, .hsel_i, .htrans_i,
  .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .serial_clock_pin_o,
  .serial_clock_pin_oe_o, .sleep_i, .irq_o, .wake_o);
`default_nettype wire

// ---- tb/usr_link_partner.sv ----
// usr_link_partner: far-side serial device that sends and takes words LSB first.
// Assumes the bench resolves pin levels; makes the clock only as slave partner.
`default_nettype none
module usr_link_partner (
  // resolved clock and data pins, port mode
  input wire logic clk_wire_i,
  input wire logic data_wire_i,
  input wire logic master_mode_i,
  // partner drive
  output logic clk_o,
  output logic data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // frame sender and receiver
  // ****************************************
  initial
  begin
    clk_o = 1'h0;
    data_o = 1'h0;
  end
  // data moves just after a rise so it is steady around the falling sample
  task automatic xfer(input logic [8:0] x, input int nb);
    #3;
    for (int i = 0; i < nb; i++)
    begin
      if (master_mode_i)
        @(posedge clk_wire_i);
      else
        clk_o = 1'h1;
      #1 data_o = x[i];
      if (master_mode_i)
        @(negedge clk_wire_i);
      else
      begin
        #31 clk_o = 1'h0;
        #32;
      end
    end
    // released line shows the inverse, never a stale bit
    data_o = ~x[nb-1];
  endtask
  // master mode only: the port makes the clock, bits are taken on its fall
  task automatic grab(output logic [8:0] x, input int nb);
    x = '0;
    for (int i = 0; i < nb; i++)
    begin
      @(negedge clk_wire_i);
      x[i] = data_wire_i;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: drives the serial port over AHB-Lite and a link partner.
// Assumes a 125 MHz clock; the link clock runs at 64 ns within frames.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic hwrite, hrdy, hresp, sck_o, sck_oe, sdo, sdo_oe, sleep, irq, wake;
  logic p_clk, p_data, master, sck_w, sdt_w, sent;
  logic [31:0] lfsr = 32'h3C656D75;
  logic [8:0] w [6];
  logic [8:0] got;
  int errors = 0;
  int checked = 0;
  always #4 clk_i = ~clk_i;
  assign sck_w = sck_oe ? sck_o : p_clk;
  assign sdt_w = sdo_oe ? sdo : p_data;
  usr_sync_port usr_sync_port_inst (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(1'h1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_o(sck_oe), .serial_data_pin_i(sdt_w), .serial_data_pin_o(sdo),
    .serial_data_pin_oe_o(sdo_oe), .sleep_i(sleep), .irq_o(irq), .wake_o(wake)
  );
  usr_link_partner usr_link_partner_inst (
    .clk_wire_i(sck_w), .data_wire_i(sdt_w), .master_mode_i(master), .clk_o(p_clk), .data_o(p_data)
  );
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] rcs(input logic [7:0] c, input logic ovr, input logic nin);
    return {24'h000000, c | {6'h00, ovr, nin}};
  endfunction
  task automatic print_verdict();
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    haddr <= {24'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_i); while (hrdy !== 1'h1 && ++n < 64);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge clk_i); while (hrdy !== 1'h1 && ++n < 64);
    rd = hrdata;
    if (n >= 64)
    begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] v;
    bus(idx, 1'h1, d, v);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] v;
    bus(idx, 1'h0, 8'h00, v);
    check(v & m, exp);
  endtask
  task automatic send(input logic [8:0] x, input int nb);
    usr_link_partner_inst.xfer(x, nb);
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wait_sent();
    for (int n = 0; n < 400 && !sent; n++)
      @(posedge clk_i);
    repeat (6) @(posedge clk_i);
    if (!sent)
    begin
      errors++;
      print_verdict();
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [5:0] ri [6];
    logic [7:0] rv [6];
    int n;
    ri = '{usr_pkg::IDX_FLAGS, usr_pkg::IDX_IEN, usr_pkg::IDX_RECEIVE_STATUS_CONTROL, usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, usr_pkg::IDX_BAUD, 6'h3F};
    rv = '{8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    sleep = 1'h0;
    master = 1'h0;
    sent = 1'h0;
    for (int k = 0; k < 6; k++)
    begin
      lfsr = lfsr_next(lfsr);
      w[k] = lfsr[8:0];
    end
    w[1] = 9'h0FF;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    for (int k = 0; k < 6; k++)
      rdc(ri[k], {24'h000000, rv[k]});
    check({31'h0, hresp}, 32'h0);
    // slave receive, single enable alone must not start it
    wr(usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hE0);
    send(w[0], 9);
    rdc(usr_pkg::IDX_FLAGS, 32'h0, 32'h1);
    wr(usr_pkg::IDX_IEN, 8'h01);
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hD0);
    send(w[0], 9);
    send(w[1], 9);
    check({31'h0, irq}, 32'h1);
    send(w[2], 9);
    rdc(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, rcs(8'hD0, 1'h1, w[0][8]));
    rdc(usr_pkg::IDX_RCBUF, {24'h0, w[0][7:0]});
    send(w[3], 9);
    rdc(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, rcs(8'hD0, 1'h1, w[1][8]));
    rdc(usr_pkg::IDX_RCBUF, {24'h0, w[1][7:0]});
    rdc(usr_pkg::IDX_FLAGS, 32'h0, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    rdc(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'h80, 32'hFE);
    // a word completes while the core sleeps
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hD0);
    sleep <= 1'h1;
    send(w[4], 9);
    check({31'h0, wake}, 32'h1);
    sleep <= 1'h0;
    rdc(usr_pkg::IDX_RCBUF, {24'h0, w[4][7:0]});
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'h90);
    send(w[5], 8);
    rdc(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, rcs(8'h90, 1'h0, w[4][8]));
    rdc(usr_pkg::IDX_RCBUF, {24'h0, w[5][7:0]});
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    // master single then continuous receive; mode bits set first
    master <= 1'h1;
    wr(usr_pkg::IDX_BAUD, 8'h03);
    wr(usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
    fork
      begin
        usr_link_partner_inst.xfer(w[0], 8);
        sent = 1'h1;
      end
    join_none
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hA0);
    wait_sent();
    rdc(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'h80, 32'hFE);
    rdc(usr_pkg::IDX_RCBUF, {24'h0, w[0][7:0]});
    check({31'h0, sck_oe}, 32'h1);
    n = 0;
    repeat (32)
    begin
      @(posedge clk_i);
      n += (sck_o !== 1'h0);
    end
    check(n, 32'h0);
    sent = 1'h0;
    fork
      begin
        usr_link_partner_inst.xfer(w[1], 8);
        usr_link_partner_inst.xfer(w[2], 8);
        sent = 1'h1;
      end
    join_none
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hB0);
    wait_sent();
    wr(usr_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    rdc(usr_pkg::IDX_RCBUF, {24'h0, w[1][7:0]});
    rdc(usr_pkg::IDX_RCBUF, {24'h0, w[2][7:0]});
    // master transmit of nine bits; buffer loaded before the enable
    wr(usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, {7'h68, w[3][8]});
    wr(usr_pkg::IDX_TXBUF, w[3][7:0]);
    rdc(usr_pkg::IDX_FLAGS, 32'h0, 32'h2);
    sent = 1'h0;
    fork
      begin
        usr_link_partner_inst.grab(got, 9);
        sent = 1'h1;
      end
    join_none
    wr(usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, {7'h78, w[3][8]});
    wait_sent();
    check({23'h0, got}, {23'h0, w[3]});
    check({31'h0, sdo_oe}, 32'h1);
    rdc(usr_pkg::IDX_FLAGS, 32'h2, 32'h2);
    rdc(usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, {24'h0, 7'h79, w[3][8]});
    wr(usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
    rdc(usr_pkg::IDX_TRANSMIT_STATUS_CONTROL, 32'h92);
    check({31'h0, sdo_oe}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
